//--- design/bfe_cfg.svh
`ifndef BFE_CFG_SVH
`define BFE_CFG_SVH

`define BFE_REG_CTRL 8'h00
`define BFE_REG_STATUS 8'h04
`define BFE_REG_IRQ_STAT 8'h08
`define BFE_REG_IRQ_MASK 8'h0c
`define BFE_REG_OFFS_AE 8'h10
`define BFE_REG_OFFS_AF 8'h14
`define BFE_REG_CNT_AB 8'h18
`define BFE_REG_CNT_BA 8'h1c

`define BFE_BSIZE_LONG 2'h0
`define BFE_BSIZE_WORD 2'h1
`define BFE_BSIZE_BYTE 2'h2

`define BFE_OFS_8 16'h0008
`define BFE_OFS_16 16'h0010
`define BFE_OFS_64 16'h0040
`define BFE_OFS_256 16'h0100
`define BFE_OFS_1024 16'h0400

`define BFE_FLAG_RST 4'hc
`define BFE_LONG_MASK 36'hfffffffff
`define BFE_WORD_MASK 36'h00003ffff
`define BFE_BYTE_MASK 36'h0000001ff
`define BFE_WORD_SHIFT 18
`define BFE_BYTE_SHIFT 9
`define BFE_NUM_EVT 4

`endif

//--- design/bfe_pkg.sv
package bfe_pkg;
  typedef logic [35:0] bfe_word_t;
  typedef logic [1:0] bfe_bsize_t;
  typedef logic [1:0] bfe_piece_t;
endpackage

//--- design/bfe_fifo.sv
`timescale 1ns/1ps
// DEPTH must be a power of two: pointers wrap by overflow
module bfe_fifo #(
  parameter int DEPTH = 16384,
  parameter int W = 36,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [CW-1:0] count_ff;
  logic do_push;
  logic do_pop;

  assign full = count_ff == CW'(DEPTH);
  assign empty = count_ff == '0;
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign head = mem[rptr_ff];
  assign count = count_ff;

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr_ff] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (do_push) begin
        wptr_ff <= wptr_ff + AW'(1);
      end
      if (do_pop) begin
        rptr_ff <= rptr_ff + AW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else begin
      case ({do_push, do_pop})
        2'b10: count_ff <= count_ff + CW'(1);
        2'b01: count_ff <= count_ff - CW'(1);
        default: count_ff <= count_ff;
      endcase
    end
  end
endmodule

//--- design/bfe_sync2.sv
`timescale 1ns/1ps
module bfe_sync2 #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= RST;
      s2_ff <= RST;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;
endmodule

//--- design/bfe_top.sv
`timescale 1ns/1ps
`include "bfe_cfg.svh"
// Behaviour
// - two 36-bit bidirectional data ports, side A and side B
// - port A almost-empty low while B-to-A count <= its offset
// - port B almost-empty low while A-to-B count <= its offset
// - port A almost-full low while A-to-B free space <= its offset
// - port B almost-full low while B-to-A free space <= its offset
// - select high at reset: big-endian, most significant piece first on B
// - select low at reset: little-endian, least significant piece first on B
// - after reset the same pin picks timing: high standard, low fall-through
// - thresholds at reset from 8, 16, 64, 256 or 1024 locations
// - almost flags pass two synchroniser stages before the pins
// - one FIFO carries A writes to B reads, the other B to A
module bfe_top #(
  parameter int DEPTH = 16384
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bfe_pkg::bfe_word_t side_a_data_bus_i,
  output bfe_pkg::bfe_word_t side_a_data_bus_o,
  output logic side_a_data_bus_oe,
  input wire logic a_cs_n,
  input wire logic a_wr_en,
  input wire logic a_rd_en,
  input wire bfe_pkg::bfe_word_t side_b_data_bus_i,
  output bfe_pkg::bfe_word_t side_b_data_bus_o,
  output logic side_b_data_bus_oe,
  input wire logic b_cs_n,
  input wire logic b_wr_en,
  input wire logic b_rd_en,
  input wire logic endian_or_timing_select,
  input wire logic [2:0] offset_select,
  output logic port_a_almost_empty,
  output logic port_b_almost_empty,
  output logic port_a_almost_full,
  output logic port_b_almost_full,
  output logic irq
);
  import bfe_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  logic cap_done_ff;
  logic endian_ff;
  logic fwft_ff;
  logic [CW-1:0] almost_empty_a_offset_ff;
  logic [CW-1:0] almost_empty_b_offset_ff;
  logic [CW-1:0] almost_full_a_offset_ff;
  logic [CW-1:0] almost_full_b_offset_ff;
  bfe_bsize_t bsize_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] flags_prev_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  bfe_word_t a_dout_ff;
  logic a_valid_ff;
  logic a_oe_ff;
  bfe_word_t b_dout_ff;
  bfe_word_t b_hold_ff;
  logic b_valid_ff;
  logic b_oe_ff;
  bfe_piece_t b_rpiece_ff;
  bfe_piece_t b_wpiece_ff;
  bfe_word_t b_asm_ff;

  bfe_word_t ab_head;
  bfe_word_t ba_head;
  logic [CW-1:0] cnt_ab;
  logic [CW-1:0] cnt_ba;
  logic [CW-1:0] free_ab;
  logic [CW-1:0] free_ba;
  logic ab_full;
  logic ab_empty;
  logic ba_full;
  logic ba_empty;
  logic a_push;
  logic ab_pop;
  logic ba_push;
  logic ba_pop;
  logic a_rd;
  logic a_load;
  logic b_rd;
  logic b_wr;
  logic b_load;
  bfe_piece_t b_last;
  bfe_piece_t b_rphys;
  bfe_piece_t b_wphys;
  bfe_word_t b_rword;
  bfe_word_t nxt_b_asm;
  logic [3:0] flags_raw;
  logic [3:0] flags_q;
  logic [3:0] flag_evt;
  logic apb_setup;
  logic apb_write;
  logic [31:0] rd_mux;
  logic rd_hit;

  function automatic logic [15:0] strap_offset(input logic [2:0] s);
    case (s)
      3'h0: strap_offset = `BFE_OFS_8;
      3'h1: strap_offset = `BFE_OFS_16;
      3'h2: strap_offset = `BFE_OFS_64;
      3'h3: strap_offset = `BFE_OFS_256;
      default: strap_offset = `BFE_OFS_1024;
    endcase
  endfunction

  function automatic bfe_piece_t piece_last(input bfe_bsize_t sz);
    case (sz)
      `BFE_BSIZE_WORD: piece_last = 2'h1;
      `BFE_BSIZE_BYTE: piece_last = 2'h3;
      default: piece_last = 2'h0;
    endcase
  endfunction

  function automatic bfe_word_t piece_mask(input bfe_bsize_t sz);
    case (sz)
      `BFE_BSIZE_WORD: piece_mask = `BFE_WORD_MASK;
      `BFE_BSIZE_BYTE: piece_mask = `BFE_BYTE_MASK;
      default: piece_mask = `BFE_LONG_MASK;
    endcase
  endfunction

  function automatic int piece_shift(input bfe_bsize_t sz, input bfe_piece_t idx);
    case (sz)
      `BFE_BSIZE_WORD: piece_shift = int'(idx) * `BFE_WORD_SHIFT;
      `BFE_BSIZE_BYTE: piece_shift = int'(idx) * `BFE_BYTE_SHIFT;
      default: piece_shift = 0;
    endcase
  endfunction

  // strap capture on the first edge after release; ports idle until then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_done_ff <= 1'b0;
      endian_ff <= 1'b0;
      fwft_ff <= 1'b0;
      almost_empty_a_offset_ff <= '0;
      almost_empty_b_offset_ff <= '0;
      almost_full_a_offset_ff <= '0;
      almost_full_b_offset_ff <= '0;
    end else if (!cap_done_ff) begin
      cap_done_ff <= 1'b1;
      endian_ff <= endian_or_timing_select;
      almost_empty_a_offset_ff <= CW'(strap_offset(offset_select));
      almost_empty_b_offset_ff <= CW'(strap_offset(offset_select));
      almost_full_a_offset_ff <= CW'(strap_offset(offset_select));
      almost_full_b_offset_ff <= CW'(strap_offset(offset_select));
    end else begin
      // sampled every cycle; a pin that moves mid-stream changes timing
      fwft_ff <= ~endian_or_timing_select;
    end
  end

  bfe_fifo #(.DEPTH(DEPTH), .W(36)) u_fifo_a_to_b (
    .pclk(pclk),
    .presetn(presetn),
    .push(a_push),
    .push_data(side_a_data_bus_i),
    .pop(ab_pop),
    .head(ab_head),
    .count(cnt_ab),
    .full(ab_full),
    .empty(ab_empty)
  );

  bfe_fifo #(.DEPTH(DEPTH), .W(36)) u_fifo_b_to_a (
    .pclk(pclk),
    .presetn(presetn),
    .push(ba_push),
    .push_data(nxt_b_asm),
    .pop(ba_pop),
    .head(ba_head),
    .count(cnt_ba),
    .full(ba_full),
    .empty(ba_empty)
  );

  // port A: writes feed A-to-B, reads drain B-to-A
  assign a_push = cap_done_ff & ~a_cs_n & a_wr_en & ~ab_full;
  assign a_rd = cap_done_ff & ~a_cs_n & ~a_wr_en & a_rd_en;
  assign a_load = fwft_ff ? ((~a_valid_ff | a_rd) & ~ba_empty) : (a_rd & ~ba_empty);
  assign ba_pop = a_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dout_ff <= '0;
      a_valid_ff <= 1'b0;
      a_oe_ff <= 1'b0;
    end else begin
      if (a_load) begin
        a_dout_ff <= ba_head;
      end
      a_valid_ff <= fwft_ff & (a_load | (a_valid_ff & ~a_rd));
      a_oe_ff <= cap_done_ff & ~a_cs_n & ~a_wr_en;
    end
  end

  // port B: long words split into pieces in the captured byte order
  assign b_last = piece_last(bsize_ff);
  assign b_rd = cap_done_ff & ~b_cs_n & ~b_wr_en & b_rd_en;
  assign b_wr = cap_done_ff & ~b_cs_n & b_wr_en & ~ba_full;
  assign b_rphys = endian_ff ? b_last - b_rpiece_ff : b_rpiece_ff;
  assign b_wphys = endian_ff ? b_last - b_wpiece_ff : b_wpiece_ff;
  assign b_rword = (b_rpiece_ff == 2'h0) ? ab_head : b_hold_ff;
  assign b_load = fwft_ff ? ((~b_valid_ff | b_rd) & ((b_rpiece_ff != 2'h0) | ~ab_empty))
                          : (b_rd & ((b_rpiece_ff != 2'h0) | ~ab_empty));
  assign ab_pop = b_load & (b_rpiece_ff == 2'h0);
  assign nxt_b_asm = (b_asm_ff & ~(piece_mask(bsize_ff) << piece_shift(bsize_ff, b_wphys)))
                   | ((side_b_data_bus_i & piece_mask(bsize_ff))
                      << piece_shift(bsize_ff, b_wphys));
  assign ba_push = b_wr & (b_wpiece_ff == b_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_dout_ff <= '0;
      b_hold_ff <= '0;
      b_valid_ff <= 1'b0;
      b_oe_ff <= 1'b0;
      b_rpiece_ff <= 2'h0;
    end else begin
      if (apb_write && paddr == `BFE_REG_CTRL) begin
        // a size change abandons a part-read word
        b_rpiece_ff <= 2'h0;
      end else if (b_load) begin
        b_dout_ff <= (b_rword >> piece_shift(bsize_ff, b_rphys)) & piece_mask(bsize_ff);
        b_rpiece_ff <= (b_rpiece_ff == b_last) ? 2'h0 : b_rpiece_ff + 2'h1;
      end
      if (ab_pop) begin
        b_hold_ff <= ab_head;
      end
      b_valid_ff <= fwft_ff & (b_load | (b_valid_ff & ~b_rd));
      b_oe_ff <= cap_done_ff & ~b_cs_n & ~b_wr_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_wpiece_ff <= 2'h0;
      b_asm_ff <= '0;
    end else if (apb_write && paddr == `BFE_REG_CTRL) begin
      b_wpiece_ff <= 2'h0;
    end else if (b_wr) begin
      b_asm_ff <= nxt_b_asm;
      b_wpiece_ff <= (b_wpiece_ff == b_last) ? 2'h0 : b_wpiece_ff + 2'h1;
    end
  end

  assign side_a_data_bus_o = a_dout_ff;
  assign side_a_data_bus_oe = a_oe_ff;
  assign side_b_data_bus_o = b_dout_ff;
  assign side_b_data_bus_oe = b_oe_ff;

  // flags: high means clear of the threshold
  assign free_ab = CW'(DEPTH) - cnt_ab;
  assign free_ba = CW'(DEPTH) - cnt_ba;
  assign flags_raw[0] = cnt_ba > almost_empty_a_offset_ff;
  assign flags_raw[1] = cnt_ab > almost_empty_b_offset_ff;
  assign flags_raw[2] = free_ab > almost_full_a_offset_ff;
  assign flags_raw[3] = free_ba > almost_full_b_offset_ff;

  bfe_sync2 #(.W(4), .RST(`BFE_FLAG_RST)) u_flag_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(flags_raw),
    .q(flags_q)
  );

  assign port_a_almost_empty = flags_q[0];
  assign port_b_almost_empty = flags_q[1];
  assign port_a_almost_full = flags_q[2];
  assign port_b_almost_full = flags_q[3];

  // events: a flag falling into its almost state
  assign flag_evt = flags_prev_ff & ~flags_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_ff <= `BFE_FLAG_RST;
      irq_stat_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      flags_prev_ff <= flags_q;
      // set wins over a same-cycle write-one-to-clear
      if (apb_write && paddr == `BFE_REG_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | flag_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | flag_evt;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign irq = irq_ff;

  // APB: one access cycle, answer computed in setup
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      `BFE_REG_CTRL: rd_mux = {30'h0, bsize_ff};
      `BFE_REG_STATUS: rd_mux = {26'h0, flags_q, fwft_ff, endian_ff};
      `BFE_REG_IRQ_STAT: rd_mux = {28'h0, irq_stat_ff};
      `BFE_REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_ff};
      `BFE_REG_OFFS_AE: rd_mux = {16'(almost_empty_b_offset_ff), 16'(almost_empty_a_offset_ff)};
      `BFE_REG_OFFS_AF: rd_mux = {16'(almost_full_b_offset_ff), 16'(almost_full_a_offset_ff)};
      `BFE_REG_CNT_AB: rd_mux = 32'(cnt_ab);
      `BFE_REG_CNT_BA: rd_mux = 32'(cnt_ba);
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~rd_hit;
      if (apb_setup) begin
        prdata_ff <= (pwrite || !rd_hit) ? 32'h0 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsize_ff <= `BFE_BSIZE_LONG;
      irq_mask_ff <= 4'h0;
    end else if (apb_write) begin
      if (paddr == `BFE_REG_CTRL) begin
        bsize_ff <= pwdata[1:0];
      end
      if (paddr == `BFE_REG_IRQ_MASK) begin
        irq_mask_ff <= pwdata[3:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ae_a_level: assert property (
    port_a_almost_empty == $past(cnt_ba > almost_empty_a_offset_ff, 2))
    else $error("port A almost-empty does not follow B-to-A count");
  a_ae_b_level: assert property (
    port_b_almost_empty == $past(cnt_ab > almost_empty_b_offset_ff, 2))
    else $error("port B almost-empty does not follow A-to-B count");
  a_af_a_level: assert property (
    port_a_almost_full == $past(free_ab > almost_full_a_offset_ff, 2))
    else $error("port A almost-full does not follow A-to-B space");
  a_af_b_level: assert property (
    port_b_almost_full == $past(free_ba > almost_full_b_offset_ff, 2))
    else $error("port B almost-full does not follow B-to-A space");
  a_big_first: assert property (
    b_load && b_rpiece_ff == 2'h0 && endian_ff && bsize_ff == `BFE_BSIZE_BYTE
    |=> side_b_data_bus_o[8:0] == $past(ab_head[35:27]) && side_b_data_bus_o[35:9] == 27'h0)
    else $error("big-endian byte read did not start with top byte");
  a_little_first: assert property (
    b_load && b_rpiece_ff == 2'h0 && !endian_ff && bsize_ff == `BFE_BSIZE_WORD
    |=> side_b_data_bus_o == {18'h0, $past(ab_head[17:0])})
    else $error("little-endian word read did not start with low word");
  a_mode_follow: assert property (
    cap_done_ff |=> fwft_ff == !$past(endian_or_timing_select))
    else $error("timing mode does not follow the select pin");
  a_offset_table: assert property (
    $rose(cap_done_ff) |-> almost_empty_a_offset_ff == CW'(strap_offset($past(offset_select))))
    else $error("threshold not loaded from reset strap");
  a_ab_carry: assert property (
    a_push && !ab_pop |=> cnt_ab == $past(cnt_ab) + CW'(1))
    else $error("port A write did not enter A-to-B FIFO");
  a_endian_hold: assert property (
    cap_done_ff |=> $stable(endian_ff) ##1 $stable(endian_ff))
    else $error("endian choice changed after capture");
endmodule

//--- testbench/bfe_port_model.sv
`timescale 1ns/1ps
// one synchronous bus master on a data port; drives the shared wire when it writes
module bfe_port_model (
  input wire logic pclk,
  input wire bfe_pkg::bfe_word_t dut_o,
  input wire logic dut_oe,
  output bfe_pkg::bfe_word_t wire_lvl,
  output logic cs_n,
  output logic wr_en,
  output logic rd_en
);
  import bfe_pkg::*;
  logic drv;
  bfe_word_t d;
  bfe_word_t last;
  // released wire shows the inverse of the last word, so stale data never passes
  assign wire_lvl = dut_oe ? dut_o : (drv ? d : ~last);
  initial begin
    drv = 1'b0;
    d = '0;
    last = '0;
    cs_n = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic put(input bfe_word_t w);
    @(posedge pclk);
    cs_n <= 1'b0;
    wr_en <= 1'b1;
    drv <= 1'b1;
    d <= w;
    @(posedge pclk);
    last <= w;
    cs_n <= 1'b1;
    wr_en <= 1'b0;
    drv <= 1'b0;
  endtask
  task automatic get(output bfe_word_t w);
    @(posedge pclk);
    cs_n <= 1'b0;
    rd_en <= 1'b1;
    @(posedge pclk);
    cs_n <= 1'b1;
    rd_en <= 1'b0;
    @(posedge pclk);
    w = dut_o;
  endtask
endmodule

//--- testbench/bidir_fifo_flags_endian_mode_tb.sv
`timescale 1ns/1ps
`include "bfe_cfg.svh"
module bidir_fifo_flags_endian_mode_tb;
  import bfe_pkg::*;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bfe_word_t a_i, a_o, b_i, b_o, w, g;
  logic a_oe, b_oe, a_cs_n, a_wr, a_rd, b_cs_n, b_wr, b_rd;
  logic sel, aea, aeb, afa, afb, irq, er;
  logic [2:0] offs;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;

  bfe_top #(.DEPTH(16)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .side_a_data_bus_i(a_i), .side_a_data_bus_o(a_o),
    .side_a_data_bus_oe(a_oe), .a_cs_n(a_cs_n), .a_wr_en(a_wr), .a_rd_en(a_rd),
    .side_b_data_bus_i(b_i), .side_b_data_bus_o(b_o), .side_b_data_bus_oe(b_oe),
    .b_cs_n(b_cs_n), .b_wr_en(b_wr), .b_rd_en(b_rd), .endian_or_timing_select(sel),
    .offset_select(offs), .port_a_almost_empty(aea), .port_b_almost_empty(aeb),
    .port_a_almost_full(afa), .port_b_almost_full(afb), .irq(irq)
  );
  bfe_port_model pa (.pclk(pclk), .dut_o(a_o), .dut_oe(a_oe), .wire_lvl(a_i),
    .cs_n(a_cs_n), .wr_en(a_wr), .rd_en(a_rd));
  bfe_port_model pb (.pclk(pclk), .dut_o(b_o), .dut_oe(b_oe), .wire_lvl(b_i),
    .cs_n(b_cs_n), .wr_en(b_wr), .rd_en(b_rd));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk({4'h0, rd}, {4'h0, x});
    chk({35'h0, er}, {35'h0, xe});
  endtask

  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    sel <= s;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // strap level kept from here on: it now picks timing and must stay static
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    sel = 1'b1;
    offs = 3'h0;
    do_reset(1'b1);
    rchk(`BFE_REG_STATUS, 32'h31, 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    apb(1'b1, `BFE_REG_CTRL, 32'h2);
    apb(1'b1, `BFE_REG_IRQ_STAT, 32'hf);
    apb(1'b1, `BFE_REG_IRQ_MASK, 32'h4);
    w = 36'h123456789;
    pa.put(w);
    for (int i = 0; i < 4; i++) begin
      pb.get(g);
      chk({27'h0, g[8:0]}, {27'h0, w[35-9*i -: 9]});
    end
    // write direction: top byte goes in first on B
    for (int i = 0; i < 4; i++) pb.put({27'h0, w[35-9*i -: 9]});
    pa.get(g);
    chk(g, w);
    chk({35'h0, a_oe}, 36'h1);
    $display("test big-endian bytes done");
    for (int i = 0; i < 7; i++) pa.put(36'h100 + i);
    repeat (4) @(posedge pclk);
    chk({35'h0, afa}, 36'h1);
    pa.put(36'h107);
    // irq settles two edges after the flag itself
    repeat (5) @(posedge pclk);
    chk({35'h0, afa}, 36'h0);
    chk({35'h0, aeb}, 36'h0);
    chk({35'h0, irq}, 36'h1);
    rchk(`BFE_REG_IRQ_STAT, 32'h4, 1'b0);
    apb(1'b1, `BFE_REG_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk({35'h0, irq}, 36'h0);
    pa.put(36'h108);
    repeat (2) @(posedge pclk);
    chk({35'h0, aeb}, 36'h0);
    repeat (2) @(posedge pclk);
    chk({35'h0, aeb}, 36'h1);
    apb(1'b1, `BFE_REG_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) pb.put(36'h200 + i);
    repeat (4) @(posedge pclk);
    chk({35'h0, afb}, 36'h0);
    chk({35'h0, aea}, 36'h0);
    pb.put(36'h208);
    repeat (4) @(posedge pclk);
    chk({35'h0, aea}, 36'h1);
    pa.get(g);
    chk(g, 36'h200);
    chk({35'h0, a_oe}, 36'h1);
    pb.get(g);
    chk(g, 36'h100);
    chk({35'h0, b_oe}, 36'h1);
    $display("test almost flags done");
    // second reset in mid-run with the strap low and 16-location offsets
    offs <= 3'h1;
    do_reset(1'b0);
    rchk(`BFE_REG_STATUS, 32'h02, 1'b0);
    rchk(`BFE_REG_OFFS_AE, 32'h00100010, 1'b0);
    apb(1'b1, `BFE_REG_CTRL, 32'h1);
    w = 36'h9abcdef01;
    pb.put({18'h0, w[17:0]});
    pb.put({18'h0, w[35:18]});
    repeat (4) @(posedge pclk);
    chk(a_o, w);
    // read direction: low word falls through first, a read brings the high word
    w = 36'h2468ace13;
    pa.put(w);
    repeat (4) @(posedge pclk);
    chk(b_o, {18'h0, w[17:0]});
    pb.get(g);
    chk(g, {18'h0, w[35:18]});
    $display("test little-endian fall-through done");
    print_verdict();
  end
endmodule
